// ---- hw/dtmr_timers.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtmr_consts.svh"

// Behaviour
// R1 - two independent 8-bit up-only counters
// R2 - base count clock is system clock / 4
// R3 - control bits 2..0 pick prescaler ratio
// R4 - counter steps by one per prescaled pulse
// R5 - passing full count flags overflow, interrupt request
// R6 - overflow reloads preload, counting continues
// R7 - preload write while stopped loads counter too
// R8 - preload write while running waits for reload
// R9 - count register read returns present value
// R10 - reading count blocks timer clock that cycle
// R11 - preload zero gives full 256-step period
// R12 - control bit 4 runs or holds counter
// R13 - software writes bit6 one, bit7 zero
// R14 - request gated by interrupt enable bit
// R15 - software loads preload before starting timer
// R16 - ratio is two to the power n+1
// R17 - control bits 3, 5 stored, no effect
module dtmr_timers (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // special-purpose data memory port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic sfrRe,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  // interrupt enables from the interrupt control register
  input wire logic [1:0] intEnable,
  // events
  output wire logic [1:0] ovfPulse,
  output wire logic [1:0] intReq
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic isAddr(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    isAddr = (addr == target);
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = isAddr(addr, `DTMR_ADDR_T0_COUNT) ||
               isAddr(addr, `DTMR_ADDR_T0_CTRL) ||
               isAddr(addr, `DTMR_ADDR_T1_COUNT) ||
               isAddr(addr, `DTMR_ADDR_T1_CTRL);
  endfunction

  // ------------------------------------------------------------------
  // shared divide-by-four base clock
  // ------------------------------------------------------------------
  dtmr_pkg::dtmr_base_t baseCnt_q;
  logic baseTick;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      baseCnt_q <= `DTMR_RST_BASE;
    end else begin
      baseCnt_q <= baseCnt_q + 2'h1; // [R2]
    end
  end

  // free-running, so both timers share one phase of the base clock
  assign baseTick = (baseCnt_q == `DTMR_BASE_DIV_LAST); // [R2]

  // ------------------------------------------------------------------
  // per-timer views for the read mux
  // ------------------------------------------------------------------
  wire logic [1:0][7:0] countView;
  wire logic [1:0][7:0] ctrlView;

  // ------------------------------------------------------------------
  // the two timers
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : gTmr // [R1]
    localparam logic [7:0] CountAddr =
      (i == 0) ? `DTMR_ADDR_T0_COUNT : `DTMR_ADDR_T1_COUNT;
    localparam logic [7:0] CtrlAddr =
      (i == 0) ? `DTMR_ADDR_T0_CTRL : `DTMR_ADDR_T1_CTRL;

    dtmr_pkg::dtmr_byte_t ctrl_q;
    dtmr_pkg::dtmr_byte_t preload_q;
    dtmr_pkg::dtmr_byte_t count_q;
    dtmr_pkg::dtmr_byte_t count_d;
    dtmr_pkg::dtmr_byte_t reloadVal;
    logic ovf_q;
    logic intReq_q;
    logic ctrlWr;
    logic preWr;
    logic cntRead;
    logic run;
    logic psTick;
    logic cntTick;
    logic atFull;

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    assign ctrlWr = sfrWe && isAddr(sfrAddr, CtrlAddr);
    assign preWr = sfrWe && isAddr(sfrAddr, CountAddr);
    assign cntRead = sfrRe && isAddr(sfrAddr, CountAddr);

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    // all eight bits stored; only run and rate steer the timer
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        ctrl_q <= `DTMR_RST_CTRL;
      end else if (ctrlWr) begin
        ctrl_q <= sfrWdata; // [R17]
      end
    end

    assign run = ctrl_q[`DTMR_RUN_BIT]; // [R12]

    // ---------------------------------------------------------------
    // prescaler
    // ---------------------------------------------------------------
    dtmr_prescaler uPresc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .baseTick(baseTick),
      .run(run),
      .rateSel(ctrl_q[`DTMR_SEL_MSB:0]),
      .tick(psTick)
    );

    // a pulse landing in a read cycle is dropped, not deferred
    assign cntTick = psTick && !cntRead; // [R10]

    // ---------------------------------------------------------------
    // preload register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        preload_q <= `DTMR_RST_PRELOAD;
      end else if (preWr) begin
        preload_q <= sfrWdata;
      end
    end

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    assign atFull = (count_q == `DTMR_FULL_COUNT); // [R5]
    // a write coinciding with the reload already counts as current
    assign reloadVal = preWr ? sfrWdata : preload_q; // [R6]

    always_comb begin
      count_d = count_q;
      if (preWr && !run) begin
        count_d = sfrWdata; // [R7]
      end else if (cntTick) begin
        if (atFull) begin
          count_d = reloadVal; // [R6] [R8]
        end else begin
          count_d = count_q + 8'h01; // [R4] [R11]
        end
      end
    end

    // while running a preload write leaves the counter alone
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        count_q <= `DTMR_RST_COUNT;
      end else begin
        count_q <= count_d; // [R8] [R12]
      end
    end

    // ---------------------------------------------------------------
    // overflow and interrupt request
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        ovf_q <= 1'b0;
      end else begin
        ovf_q <= cntTick && atFull; // [R5]
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        intReq_q <= 1'b0;
      end else begin
        intReq_q <= cntTick && atFull && intEnable[i]; // [R5] [R14]
      end
    end

    assign ovfPulse[i] = ovf_q;
    assign intReq[i] = intReq_q;
    assign countView[i] = count_q;
    assign ctrlView[i] = ctrl_q;
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // the count is sampled at the same edge that the read blocks it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfrRdata <= `DTMR_RST_RDATA;
    end else if (sfrRe) begin
      if (isAddr(sfrAddr, `DTMR_ADDR_T0_COUNT)) begin
        sfrRdata <= countView[0]; // [R9]
      end else if (isAddr(sfrAddr, `DTMR_ADDR_T1_COUNT)) begin
        sfrRdata <= countView[1]; // [R9]
      end else if (isAddr(sfrAddr, `DTMR_ADDR_T0_CTRL)) begin
        sfrRdata <= ctrlView[0];
      end else if (isAddr(sfrAddr, `DTMR_ADDR_T1_CTRL)) begin
        sfrRdata <= ctrlView[1];
      end else begin
        sfrRdata <= `DTMR_RST_RDATA;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfrHit <= 1'b0;
    end else begin
      sfrHit <= sfrRe && isMapped(sfrAddr);
    end
  end

endmodule

`default_nettype wire

// ---- hw/dtmr_consts.svh ----
`ifndef DTMR_CONSTS_SVH
`define DTMR_CONSTS_SVH

// ------------------------------------------------------------------
// special-purpose data memory addresses
// ------------------------------------------------------------------
`define DTMR_ADDR_T0_COUNT 8'h0D
`define DTMR_ADDR_T0_CTRL 8'h0E
`define DTMR_ADDR_T1_COUNT 8'h10
`define DTMR_ADDR_T1_CTRL 8'h11

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define DTMR_RUN_BIT 4
`define DTMR_SEL_MSB 2
`define DTMR_SEL_MAX 3'h7

// ------------------------------------------------------------------
// counts and reset values
// ------------------------------------------------------------------
`define DTMR_BASE_DIV_LAST 2'h3
`define DTMR_FULL_COUNT 8'hFF
`define DTMR_FULL_MASK 8'hFF
`define DTMR_RST_COUNT 8'h00
`define DTMR_RST_PRELOAD 8'h00
`define DTMR_RST_CTRL 8'h00
`define DTMR_RST_RDATA 8'h00
`define DTMR_RST_PS 8'h00
`define DTMR_RST_BASE 2'h0

`endif

// ---- hw/dtmr_pkg.sv ----
package dtmr_pkg;
  typedef logic [7:0] dtmr_byte_t;
  typedef logic [2:0] dtmr_sel_t;
  typedef logic [1:0] dtmr_base_t;
endpackage

// ---- hw/dtmr_prescaler.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtmr_consts.svh"

module dtmr_prescaler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic baseTick,
  input wire logic run,
  input wire dtmr_pkg::dtmr_sel_t rateSel,
  // output
  output logic tick
);

  dtmr_pkg::dtmr_byte_t psCnt_q;
  dtmr_pkg::dtmr_byte_t psMask;

  // ratio 2^(n+1): low n+1 bits all ones marks the last base tick
  function automatic dtmr_pkg::dtmr_byte_t rateMask(
    input dtmr_pkg::dtmr_sel_t sel
  );
    rateMask = `DTMR_FULL_MASK >> (`DTMR_SEL_MAX - sel);
  endfunction

  assign psMask = rateMask(rateSel); // [R16]

  // held clear while stopped so the first period after start is whole
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      psCnt_q <= `DTMR_RST_PS;
    end else if (!run) begin
      psCnt_q <= `DTMR_RST_PS;
    end else if (baseTick) begin
      psCnt_q <= psCnt_q + 8'h01; // [R3]
    end
  end

  assign tick = run && baseTick && ((psCnt_q & psMask) == psMask); // [R3]

endmodule

`default_nettype wire

// ---- testbench/dtmr_timers_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtmr_consts.svh"
module dtmr_timers_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic sfrRe,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic sfrHit,
  // events
  input wire logic [1:0] intEnable,
  input wire logic [1:0] ovfPulse,
  input wire logic [1:0] intReq
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic mapped;
  assign mapped = sfrAddr inside {`DTMR_ADDR_T0_COUNT, `DTMR_ADDR_T0_CTRL,
    `DTMR_ADDR_T1_COUNT, `DTMR_ADDR_T1_CTRL};
  a_read_hit: assert property (sfrRe && mapped |=> sfrHit)
    else $error("mapped read gave no hit");
  a_unmapped_read: assert property (sfrRe && !mapped |=>
    !sfrHit && sfrRdata == 8'h00) else $error("unmapped read answered");
  a_hit_idle: assert property (!sfrRe |=> !sfrHit)
    else $error("hit without read");
  a_rdata_hold: assert property (!sfrRe |=> $stable(sfrRdata))
    else $error("read data moved without read");
  a_req_enabled: assert property (ovfPulse[0] && $past(intEnable[0])
    |-> intReq[0]) else $error("enabled overflow gave no request");
  a_req_masked: assert property (intReq[1] |->
    ovfPulse[1] && $past(intEnable[1])) else $error("request not allowed");
  a_ovf_single: assert property (ovfPulse[0] |=> !ovfPulse[0] [*7])
    else $error("timer0 overflows too close");
  a_ovf_gap: assert property (ovfPulse[1] |=> !ovfPulse[1] [*7])
    else $error("timer1 overflows too close");
  c_req: cover property (intReq[0]);
  c_masked: cover property (ovfPulse[1] && !intReq[1]);
  c_unmapped: cover property (sfrRe && !mapped);
endmodule
bind dtmr_timers dtmr_timers_asserts u_asserts (.clk_sys, .nrst, .sfrAddr,
  .sfrWe, .sfrRe, .sfrWdata, .sfrRdata, .sfrHit, .intEnable, .ovfPulse,
  .intReq);
`default_nettype wire

// ---- testbench/test_dtmr_timers.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtmr_consts.svh"
module test_dtmr_timers;
  logic clk_sys = 1'b0, nrst = 1'b0, sfrWe = 1'b0, sfrRe = 1'b0, sfrHit;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
  logic [7:0] v, w, p, q, cnt, ctl;
  logic [2:0] sel;
  logic [1:0] intEnable = 2'h0, ovfPulse, intReq;
  int num_errors = 0, compares = 0, c, i;
  always #4 clk_sys = ~clk_sys;
  dtmr_timers dut (.clk_sys, .nrst, .sfrAddr, .sfrWe, .sfrRe, .sfrWdata,
    .sfrRdata, .sfrHit, .intEnable, .ovfPulse, .intReq);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int exp_period(input logic [7:0] pl, input logic [2:0] s);
    return (256 - pl) * (8 << s);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfrWe <= 1'b1;
    sfrAddr <= a;
    sfrWdata <= d;
    @(posedge clk_sys);
    sfrWe <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [8:0] exp);
    @(posedge clk_sys);
    sfrRe <= 1'b1;
    sfrAddr <= a;
    @(posedge clk_sys);
    sfrRe <= 1'b0;
    #1 check({7'h00, sfrHit, sfrRdata}, {7'h00, exp});
  endtask
  // bounded wait so a dead timer cannot hang the run
  task automatic wait_ovf(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 3000) begin
        num_errors++;
        report_and_stop();
      end
    end while (ovfPulse[i] !== 1'b1);
    check(intReq[i], intEnable[i]);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    c = $urandom(32'hB2B9);
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(`DTMR_ADDR_T0_CTRL, 9'h100);
    rdc(8'h0F, 9'h000);
    for (int k = 0; k < 4; k++) begin
      i = k % 2;
      cnt = i ? `DTMR_ADDR_T1_COUNT : `DTMR_ADDR_T0_COUNT;
      ctl = i ? `DTMR_ADDR_T1_CTRL : `DTMR_ADDR_T0_CTRL;
      @(posedge clk_sys);
      intEnable <= 2'($urandom);
      v = 8'($urandom);
      wr(cnt, v);
      rdc(cnt, {1'b1, v});
      w = 8'h40 | (8'($urandom) & 8'h2F);
      wr(ctl, w);
      rdc(ctl, {1'b1, w});
      p = 8'hF0 | 8'($urandom % 16);
      q = 8'hF8 | 8'($urandom % 8);
      sel = 3'($urandom % 3);
      wr(cnt, p);
      wr(ctl, {5'h0A, sel});
      wait_ovf(c);
      wait_ovf(c);
      check(16'(c), 16'(exp_period(p, sel)));
      // the write itself spends two edges of this period
      wr(cnt, q);
      wait_ovf(c);
      check(16'(c + 2), 16'(exp_period(p, sel)));
      wait_ovf(c);
      check(16'(c), 16'(exp_period(q, sel)));
      // reads held back to back keep the counter frozen
      @(posedge clk_sys);
      sfrRe <= 1'b1;
      sfrAddr <= cnt;
      @(posedge clk_sys);
      #1 v = sfrRdata;
      repeat (40) begin
        @(posedge clk_sys);
        #1 check(sfrRdata, v);
      end
      @(posedge clk_sys);
      sfrRe <= 1'b0;
      wr(ctl, 8'h40);
      wr(cnt, v);
      repeat (100) @(posedge clk_sys);
      rdc(cnt, {1'b1, v});
      if (k < 2) begin
        wr(cnt, 8'h00);
        wr(ctl, 8'h50);
        wait_ovf(c);
        wait_ovf(c);
        check(16'(c), 16'd2048);
        wr(ctl, 8'h40);
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
